// ---- include/fesc_params.svh ----
// timing counts, offsets and field positions of the flash host
// assumes a 100 MHz aclk
`ifndef FESC_PARAMS_SVH
`define FESC_PARAMS_SVH

// ********************************************************************
// timing
// ********************************************************************
`define FESC_CLK_PERIOD_NS 10
`define FESC_T_STROBE_NS 70
`define FESC_CYC_STROBE ((`FESC_T_STROBE_NS + `FESC_CLK_PERIOD_NS - 1) / `FESC_CLK_PERIOD_NS)

// ********************************************************************
// register map, byte addresses
// ********************************************************************
`define FESC_REG_CTRL 8'h00
`define FESC_REG_ADDR 8'h04
`define FESC_REG_WDATA 8'h08
`define FESC_REG_STATUS 8'h0C
`define FESC_REG_RDATA 8'h10

// ctrl fields: op code in [2:0]
`define FESC_CTRL_OP_LSB 0
// status fields
`define FESC_ST_BUSY 0
`define FESC_ST_ERR 1
`define FESC_ST_AUTOSEL 2
`define FESC_ST_SUSP 3
`define FESC_ST_READY_PIN 4

// ********************************************************************
// command codes and unlock addresses
// ********************************************************************
`define FESC_UNLOCK_A1 21'h000555
`define FESC_UNLOCK_A2 21'h0002AA
`define FESC_UNLOCK_D1 8'hAA
`define FESC_UNLOCK_D2 8'h55
`define FESC_CMD_PROGRAM 8'hA0
`define FESC_CMD_AUTOSEL 8'h90
`define FESC_CMD_RESET 8'hF0
`define FESC_CMD_SUSPEND 8'hB0
`define FESC_CMD_RESUME 8'h30

// status bit positions on the data bus
`define FESC_POLL_BIT 7
`define FESC_TLIMIT_BIT 5

`endif

// ---- include/fesc_pkg.sv ----
// types shared by the flash erase/status host controller
// assumes fesc_params.svh holds all numeric constants
package fesc_pkg;

    // operations software can launch through the ctrl register
    typedef enum logic [2:0] {
        FESC_OP_READ,
        FESC_OP_RESET,
        FESC_OP_AUTOSEL,
        FESC_OP_PROGRAM,
        FESC_OP_SUSPEND,
        FESC_OP_RESUME,
        FESC_OP_POLL
    } fesc_op_t;

    // flash bus cycle phases
    typedef enum logic [2:0] {
        FESC_S_IDLE,
        FESC_S_SETUP,
        FESC_S_STROBE,
        FESC_S_HOLD,
        FESC_S_NEXT
    } fesc_state_t;

endpackage : fesc_pkg

// ---- logic/fesc_host.sv ----
// host controller driving a parallel nor flash by its strobes
// assumes flash pins synchronous to aclk, software on axi4-lite
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "fesc_params.svh"

module fesc_host #(
    parameter int ADDR_W = 21
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_in,
    input wire logic op_done_indicator
);

    localparam logic [3:0] CYC_STROBE = 4'(`FESC_CYC_STROBE);
    default clocking fesc_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ****************************************************************
    // register file and axi4-lite slave
    // ****************************************************************
    logic aw_got_ff, w_got_ff, ar_got_ff;
    logic [7:0] aw_addr_ff, ar_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [7:0] wdata_ff, rdata_ff;
    fesc_pkg::fesc_op_t op_ff;
    logic busy_ff, err_ff, autosel_ff, susp_ff;
    logic start_ff;
    logic [31:0] status_word;
    logic wr_fire;

    assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;
    assign status_word = {27'h0, op_done_indicator, susp_ff, autosel_ff, err_ff, busy_ff};

    // aw and w caught in any order, answered once both sit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h0;
            w_strb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                unique case (aw_addr_ff)
                    `FESC_REG_CTRL, `FESC_REG_ADDR, `FESC_REG_WDATA,
                    `FESC_REG_STATUS, `FESC_REG_RDATA: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // software registers; ctrl writes while busy are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_ff <= '0;
            wdata_ff <= 8'h00;
            op_ff <= fesc_pkg::FESC_OP_READ;
            start_ff <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            if (wr_fire && w_strb_ff[0]) begin
                unique case (aw_addr_ff)
                    `FESC_REG_CTRL: begin
                        if (!busy_ff) begin
                            op_ff <= fesc_pkg::fesc_op_t'(w_data_ff[`FESC_CTRL_OP_LSB +: 3]);
                            start_ff <= 1'b1;
                        end
                    end
                    `FESC_REG_ADDR: addr_ff <= w_data_ff[ADDR_W-1:0];
                    `FESC_REG_WDATA: wdata_ff <= w_data_ff[7:0];
                    default: ;
                endcase
            end
        end
    end

    // read channel, one access at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_got_ff <= 1'b0;
            ar_addr_ff <= 8'h00;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            ar_got_ff <= 1'b1;
            ar_addr_ff <= s_axi_araddr;
            s_axi_arready <= 1'b0;
        end else if (ar_got_ff && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            unique case (ar_addr_ff)
                `FESC_REG_CTRL: s_axi_rdata <= {29'h0, op_ff};
                `FESC_REG_ADDR: s_axi_rdata <= 32'(addr_ff);
                `FESC_REG_WDATA: s_axi_rdata <= {24'h0, wdata_ff};
                `FESC_REG_STATUS: s_axi_rdata <= status_word;
                `FESC_REG_RDATA: s_axi_rdata <= {24'h0, rdata_ff};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            ar_got_ff <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************************************
    // flash command sequencer
    // ****************************************************************
    fesc_pkg::fesc_state_t state_ff;
    logic [1:0] step_ff;
    logic [3:0] cnt_ff;
    logic cyc_rd, cyc_last;
    logic [ADDR_W-1:0] cyc_addr;
    logic [7:0] cyc_data;
    logic hit_ff, done_ff, done_poll_ok;
    logic [7:0] last_wr_ff;
    logic poll_match;

    // poll target is wdata bit 7; erase polls with wdata FFh
    // program and erase poll target
    assign poll_match = flash_dq_in[`FESC_POLL_BIT] == wdata_ff[`FESC_POLL_BIT];

    // bus cycle contents per step
    always_comb begin
        cyc_rd = 1'b0;
        cyc_last = 1'b1;
        cyc_addr = addr_ff;
        cyc_data = wdata_ff;
        unique case (op_ff)
            fesc_pkg::FESC_OP_READ, fesc_pkg::FESC_OP_POLL: cyc_rd = 1'b1;
            fesc_pkg::FESC_OP_RESET: cyc_data = `FESC_CMD_RESET;
            fesc_pkg::FESC_OP_SUSPEND: cyc_data = `FESC_CMD_SUSPEND;
            fesc_pkg::FESC_OP_RESUME: cyc_data = `FESC_CMD_RESUME;
            default: begin
                // two unlock cycles then the command
                cyc_last = (op_ff == fesc_pkg::FESC_OP_AUTOSEL) ? (step_ff == 2'd2)
                                                               : (step_ff == 2'd3);
                unique case (step_ff)
                    2'd0: begin
                        cyc_addr = ADDR_W'(`FESC_UNLOCK_A1);
                        cyc_data = `FESC_UNLOCK_D1;
                    end
                    2'd1: begin
                        cyc_addr = ADDR_W'(`FESC_UNLOCK_A2);
                        cyc_data = `FESC_UNLOCK_D2;
                    end
                    2'd2: begin
                        cyc_addr = ADDR_W'(`FESC_UNLOCK_A1);
                        cyc_data = (op_ff == fesc_pkg::FESC_OP_AUTOSEL) ? `FESC_CMD_AUTOSEL
                                                                       : `FESC_CMD_PROGRAM;
                    end
                    2'd3: ;
                endcase
            end
        endcase
    end

    // setup, strobe low for the least width, hold
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= fesc_pkg::FESC_S_IDLE;
            step_ff <= 2'd0;
            cnt_ff <= 4'h0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            flash_addr <= '0;
            flash_dq_out <= 8'h00;
        end else begin
            done_ff <= 1'b0;
            unique case (state_ff)
                fesc_pkg::FESC_S_IDLE: begin
                    if (start_ff) begin
                        busy_ff <= 1'b1;
                        step_ff <= 2'd0;
                        state_ff <= fesc_pkg::FESC_S_SETUP;
                    end
                end
                fesc_pkg::FESC_S_SETUP: begin
                    flash_ce_n <= 1'b0;
                    flash_addr <= cyc_addr;
                    flash_dq_out <= cyc_data;
                    flash_dq_oe <= !cyc_rd;
                    cnt_ff <= 4'h0;
                    state_ff <= fesc_pkg::FESC_S_STROBE;
                end
                fesc_pkg::FESC_S_STROBE: begin
                    flash_we_n <= cyc_rd;
                    flash_oe_n <= !cyc_rd;
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == CYC_STROBE) begin
                        flash_we_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        state_ff <= fesc_pkg::FESC_S_HOLD;
                    end
                end
                fesc_pkg::FESC_S_HOLD: begin
                    flash_ce_n <= 1'b1;
                    flash_dq_oe <= 1'b0;
                    state_ff <= fesc_pkg::FESC_S_NEXT;
                end
                fesc_pkg::FESC_S_NEXT: begin
                    // poll ends one read after the match, so all bits settle
                    if (!cyc_last) begin
                        step_ff <= step_ff + 2'd1;
                        state_ff <= fesc_pkg::FESC_S_SETUP;
                    end else if (op_ff == fesc_pkg::FESC_OP_POLL && !(hit_ff && done_poll_ok)
                                 && !err_ff) begin
                        state_ff <= fesc_pkg::FESC_S_SETUP;
                    end else begin
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                        state_ff <= fesc_pkg::FESC_S_IDLE;
                    end
                end
                default: state_ff <= fesc_pkg::FESC_S_IDLE;
            endcase
        end
    end

    // hit: matched read; ok: the read after it
    logic sample;
    assign sample = (state_ff == fesc_pkg::FESC_S_STROBE) && (cnt_ff == CYC_STROBE) && cyc_rd;

    // status is judged only from reads at the program address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_ff <= 8'h00;
            hit_ff <= 1'b0;
            done_poll_ok <= 1'b0;
            err_ff <= 1'b0;
        end else if (start_ff) begin
            hit_ff <= 1'b0;
            done_poll_ok <= 1'b0;
            err_ff <= 1'b0;
        end else if (sample) begin
            rdata_ff <= flash_dq_in;
            done_poll_ok <= hit_ff;
            if (poll_match) begin
                hit_ff <= 1'b1;
            end else if (flash_dq_in[`FESC_TLIMIT_BIT] && op_ff == fesc_pkg::FESC_OP_POLL) begin
                // a limit overrun is only final when the poll bit still disagrees
                err_ff <= 1'b1;
            end
        end
    end

    // mode tracking from finished commands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            autosel_ff <= 1'b0;
            susp_ff <= 1'b0;
            last_wr_ff <= 8'h00;
        end else if (done_ff) begin
            if (!cyc_rd) begin
                last_wr_ff <= cyc_data;
            end
            unique case (op_ff)
                fesc_pkg::FESC_OP_AUTOSEL: autosel_ff <= 1'b1;
                // only the reset command leaves auto-select
                fesc_pkg::FESC_OP_RESET: autosel_ff <= 1'b0;
                fesc_pkg::FESC_OP_SUSPEND: susp_ff <= 1'b1;
                // resume continues the erase; a second one is harmless
                fesc_pkg::FESC_OP_RESUME: susp_ff <= 1'b0;
                // program while suspended is allowed, suspension stays
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_strobe_low;
        $fell(flash_we_n) ##0 !flash_we_n[*7];
    endsequence
    property p_strobe_width;
        $fell(flash_we_n) |-> s_strobe_low;
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("write strobe too short");
    property p_no_clash;
        !(flash_dq_oe && !flash_oe_n);
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("host drives data during read");
    property p_autosel_cmd;
        $rose(autosel_ff) |-> last_wr_ff == `FESC_CMD_AUTOSEL;
    endproperty
    a_autosel_cmd: assert property (p_autosel_cmd) else $error("auto-select without command");
    property p_reset_exit;
        $fell(autosel_ff) |-> last_wr_ff == `FESC_CMD_RESET;
    endproperty
    a_reset_exit: assert property (p_reset_exit) else $error("auto-select left without reset");
    property p_resume_exit;
        $fell(susp_ff) |-> last_wr_ff == `FESC_CMD_RESUME;
    endproperty
    a_resume_exit: assert property (p_resume_exit) else $error("suspend left without resume");
    property p_poll_addr;
        (!flash_oe_n && op_ff == fesc_pkg::FESC_OP_POLL) |-> flash_addr == addr_ff;
    endproperty
    a_poll_addr: assert property (p_poll_addr) else $error("poll read off program address");
    property p_poll_later;
        (done_ff && op_ff == fesc_pkg::FESC_OP_POLL && !err_ff) |-> done_poll_ok && hit_ff;
    endproperty
    a_poll_later: assert property (p_poll_later) else $error("poll ended on matching read");
    property p_bvalid_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");
    property p_rvalid_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("rvalid or rdata changed");

endmodule : fesc_host

// ---- bench/fesc_flash_model.sv ----
// flash device model: commands, status bits, op-done pin
// assumes pins move after aclk edges; erase_go starts a sector erase
`timescale 1ns/100ps
module fesc_flash_model #(
    parameter int PROG_CYC = 60,
    parameter int PROT_CYC = 100,
    parameter int TO_CYC = 200,
    parameter int SUSP_CYC = 50,
    parameter int ERASE_CYC = 1500,
    parameter logic [7:0] MFR_CODE = 8'h5C, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'hD3 // arbitrary value
) (
    input wire logic aclk,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [20:0] addr,
    input wire logic [7:0] dq_w,
    input wire logic erase_go,
    output logic [7:0] dq_r,
    output logic op_done_indicator
);
    // ********************************************************************
    // state: sector 1 is the one under erase, sector 2 is protected
    // ********************************************************************
    logic [7:0] mem [0:255];
    logic [20:0] wa = 21'h000000;
    logic [7:0] wd = 8'h00, pd = 8'h00, pa = 8'h00, last = 8'h00;
    logic we_q = 1'h1, oe_q = 1'h1, asel = 1'h0, susp = 1'h0, t1 = 1'h0, t2 = 1'h0;
    logic pprot = 1'h0, sel, run;
    int step = 0, pcnt = 0, tcnt = 0, ecnt = 0, scnt = 0;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
    // busy from the last write edge
    assign run = pcnt > 0 || ((tcnt > 0 || ecnt > 0) && !susp);
    assign op_done_indicator = !run; // open drain, pulled up when released
    assign sel = addr[20:16] == 5'h01;
    // timers, toggles and command decode
    always @(posedge aclk) begin
        we_q <= we_n;
        oe_q <= oe_n;
        if (!we_n && !ce_n) begin
            wa <= addr;
            wd <= dq_w;
        end
        if (!oe_n && !ce_n) last <= dq_r;
        if (!oe_n && oe_q && !ce_n) begin
            t1 <= t1 ^ run;
            t2 <= t2 ^ (sel && (tcnt > 0 || ecnt > 0));
        end
        if (pcnt > 0) pcnt <= pcnt - 1;
        if (pcnt == 1 && !pprot) mem[pa] <= pd;
        if (tcnt > 0 && !susp) tcnt <= tcnt - 1;
        if (tcnt == 1 && !susp) ecnt <= ERASE_CYC;
        if (ecnt > 0 && !susp) ecnt <= ecnt - 1;
        // suspend lands after a bounded delay
        if (scnt > 0) scnt <= scnt - 1;
        if (scnt == 1) susp <= 1'h1;
        if (erase_go) tcnt <= TO_CYC;
        if (we_n && !we_q) begin
            step <= 0;
            // only suspend gets through while erasing; nothing gets through while programming or suspending
            if (pcnt > 0 || scnt > 0 || (wd != 8'hB0 && ecnt > 0 && !susp)) begin
                step <= 0;
            end else if (step == 3) begin
                pa <= wa[7:0];
                pd <= wd;
                pprot <= wa[20:16] == 5'h02;
                pcnt <= (wa[20:16] == 5'h02) ? PROT_CYC : PROG_CYC;
            end else if (wd == 8'hF0) begin
                asel <= 1'h0;
            end else if (wd == 8'hB0) begin
                if (tcnt > 0) begin
                    tcnt <= 0;
                    ecnt <= ERASE_CYC;
                    susp <= 1'h1;
                end else if (ecnt > 0 && !susp) scnt <= SUSP_CYC;
            end else if (wd == 8'h30) begin
                susp <= 1'h0;
            end else if (wd == 8'hAA && wa[10:0] == 11'h555) step <= 1;
            else if (step == 1 && wd == 8'h55 && wa[10:0] == 11'h2AA) step <= 2;
            else if (step == 2 && wd == 8'hA0) step <= 3;
            else if (step == 2 && wd == 8'h90) asel <= 1'h1;
        end
    end
    // read data, limit flag held 0
    always_comb begin
        if (oe_n || ce_n) dq_r = ~last; // released bus must not hold its last value
        else if (pcnt > 0) dq_r = {~pd[7], t1, 6'h00};
        else if (asel) dq_r = (addr[1:0] == 2'h0) ? MFR_CODE : (addr[1:0] == 2'h1) ?
            DEV_CODE : {7'h00, addr[20:16] == 5'h02};
        else if (sel && susp) dq_r = {1'h1, t1, 3'h0, t2, 2'h0};
        else if (sel && (tcnt > 0 || ecnt > 0)) dq_r = {1'h0, t1, 2'h0, ecnt > 0, t2, 2'h0};
        else dq_r = mem[addr[7:0]];
    end
endmodule : fesc_flash_model

// ---- bench/flash_erase_suspend_status_tb.sv ----
// self-checking bench for the flash host controller
// assumes the flash model on the pins and axi4-lite tasks as software
`timescale 1ns/100ps
`include "fesc_params.svh"
module flash_erase_suspend_status_tb;
    localparam logic [20:0] ESEC = 21'h010000;
    localparam logic [7:0] MFR = 8'h5C; // arbitrary value
    localparam logic [7:0] DEV = 8'hD3; // arbitrary value
    logic aclk, aresetn, erase_go, op_done_indicator;
    logic [7:0] s_axi_awaddr, s_axi_araddr, flash_dq_out, flash_dq_in, dq_r;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe;
    logic [20:0] flash_addr;
    int miscompares = 0, total_checks = 0, cyc = 0;
    fesc_host #(.ADDR_W(21)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_addr, .flash_dq_out, .flash_dq_oe,
        .flash_dq_in, .op_done_indicator);
    fesc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash_u (.aclk,
        .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n), .addr(flash_addr),
        .dq_w(flash_dq_in), .erase_go, .dq_r, .op_done_indicator);
    assign flash_dq_in = flash_dq_oe ? flash_dq_out : dq_r; // shared data wire
    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end
    // ********************************************************************
    // compares and bus tasks
    // ********************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t data %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t response %h expected %h", $time, got, exp);
        end
    endtask : chk_resp
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : axi_rd
    // run one flash operation, wait for idle, fetch status and data
    task automatic op_rd(input fesc_pkg::fesc_op_t op, input logic [20:0] fa,
            input logic [7:0] wd, output logic [31:0] st, output logic [31:0] d);
        logic [1:0] r;
        axi_wr(`FESC_REG_ADDR, {11'h0, fa}, r);
        axi_wr(`FESC_REG_WDATA, {24'h0, wd}, r);
        axi_wr(`FESC_REG_CTRL, {29'h0, op}, r);
        do axi_rd(`FESC_REG_STATUS, st, r);
        while (st[`FESC_ST_BUSY] !== 1'h0);
        axi_rd(`FESC_REG_RDATA, d, r);
    endtask : op_rd
    task automatic rd(input logic [20:0] fa, output logic [31:0] st, output logic [31:0] d);
        op_rd(fesc_pkg::FESC_OP_READ, fa, 8'h00, st, d);
    endtask : rd
    // ********************************************************************
    // scenarios
    // ********************************************************************
    task automatic t_regs_and_program();
        logic [31:0] st, d;
        logic [1:0] r;
        axi_rd(`FESC_REG_STATUS, d, r);
        chk(d, 32'h10);
        axi_rd(8'h20, d, r);
        chk_resp(r, 2'h2);
        axi_wr(8'h24, 32'h1, r);
        chk_resp(r, 2'h2);
        op_rd(fesc_pkg::FESC_OP_PROGRAM, 21'h000010, 8'h5A, st, d);
        chk(st & 32'h10, 32'h00);
        op_rd(fesc_pkg::FESC_OP_POLL, 21'h000010, 8'h5A, st, d);
        chk(d, 32'h5A);
        chk(st & 32'h12, 32'h10);
        op_rd(fesc_pkg::FESC_OP_PROGRAM, 21'h020020, 8'hA5, st, d);
        op_rd(fesc_pkg::FESC_OP_POLL, 21'h020020, 8'hA5, st, d);
        chk(d, 32'hFF);
    endtask : t_regs_and_program
    task automatic t_autoselect();
        logic [31:0] st, d;
        op_rd(fesc_pkg::FESC_OP_AUTOSEL, 21'h000000, 8'h00, st, d);
        chk(st & 32'h04, 32'h04);
        for (int i = 0; i < 4; i++) begin
            rd(21'(4 * i), st, d);
            chk(d, {24'h0, MFR});
        end
        rd(21'h000001, st, d);
        chk(d, {24'h0, DEV});
        rd(21'h020002, st, d);
        chk(d, 32'h01);
        rd(21'h000002, st, d);
        chk(d, 32'h00);
        op_rd(fesc_pkg::FESC_OP_RESET, 21'h000000, 8'h00, st, d);
        rd(21'h000010, st, d);
        chk(d, 32'h5A);
    endtask : t_autoselect
    task automatic t_suspend();
        logic [31:0] st, d, d2;
        int c0;
        erase_go <= 1'h1;
        @(posedge aclk);
        erase_go <= 1'h0;
        op_rd(fesc_pkg::FESC_OP_SUSPEND, 21'h000000, 8'h00, st, d);
        chk(st & 32'h18, 32'h18);
        rd(ESEC, st, d);
        rd(ESEC, st, d2);
        chk(d & 32'hA0, 32'h80);
        chk(d2 & 32'h44, (d & 32'h44) ^ 32'h04);
        op_rd(fesc_pkg::FESC_OP_AUTOSEL, 21'h000000, 8'h00, st, d);
        rd(ESEC, st, d);
        chk(d, {24'h0, MFR});
        op_rd(fesc_pkg::FESC_OP_RESET, 21'h000000, 8'h00, st, d);
        rd(ESEC, st, d);
        chk(d & 32'h80, 32'h80);
        op_rd(fesc_pkg::FESC_OP_PROGRAM, 21'h000030, 8'h3C, st, d);
        chk(st & 32'h10, 32'h00);
        op_rd(fesc_pkg::FESC_OP_POLL, 21'h000030, 8'h3C, st, d);
        chk(d, 32'h3C);
        rd(21'h000010, st, d);
        chk(d, 32'h5A);
        op_rd(fesc_pkg::FESC_OP_RESUME, 21'h000000, 8'h00, st, d);
        op_rd(fesc_pkg::FESC_OP_RESUME, 21'h000000, 8'h00, st, d);
        rd(ESEC, st, d);
        rd(ESEC, st, d2);
        chk(d & 32'hA8, 32'h08);
        chk((d ^ d2) & 32'h40, 32'h40);
        chk(st & 32'h18, 32'h00);
        c0 = cyc;
        op_rd(fesc_pkg::FESC_OP_SUSPEND, 21'h000000, 8'h00, st, d);
        do rd(ESEC, st, d);
        while (d[7] !== 1'h1 && cyc - c0 < 2000);
        chk(d & 32'h80, 32'h80);
        op_rd(fesc_pkg::FESC_OP_RESUME, 21'h000000, 8'h00, st, d);
        op_rd(fesc_pkg::FESC_OP_POLL, ESEC, 8'hFF, st, d);
        chk(d, 32'hFF);
        chk(st & 32'h12, 32'h10);
    endtask : t_suspend
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    // watchdog; the run needs well under this
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            $display("[ERR] %0t run timed out", $time);
            complete_run();
        end
    end
    initial begin
        {aresetn, erase_go, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs_and_program();
        t_autoselect();
        t_suspend();
        complete_run();
    end
endmodule : flash_erase_suspend_status_tb
